// File: src/sslp_top.sv
// Serial word shifter, latch bank and double buffered settings
`timescale 1ns/1ps
module sslp_top
   import sslp_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Three wire serial link
   input wire logic serial_clock,
   input wire logic serial_data,
   input wire logic latch_strobe,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Internal sources for the mux output
   input wire logic digital_lock,
   input wire logic analog_lock,
   input wire logic ref_scaled,
   input wire logic rf_scaled,
   // Settings in use
   output sslp_active_s active,
   output logic ref_differential,
   output logic [2:0] mux_select,
   output logic integer_mode,
   output logic [1:0] pfd_multiplier,
   output logic [10:0] pfd_divisor,
   output logic config_valid,
   output logic test_mux_output,
   output logic cal_busy,
   output logic loop_active
);

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic [2:0] link_s;              // Synchronised link pins
   logic [3:0] src_s;               // Synchronised mux sources
   logic sclk_d;                    // Serial clock, one cycle late
   logic strobe_d;                  // Strobe, one cycle late
   logic sclk_rise;                 // Serial clock edge seen
   logic strobe_rise;               // Strobe edge seen
   logic [WORD_W-1:0] shreg;        // Input shift register
   logic [WORD_W-1:0] latch_mem [LATCH_COUNT]; // Latch bank
   logic [SEL_W-1:0] wr_sel;        // Destination selector
   logic wr_evt;                    // Word goes into a latch
   logic [7:0] wr_count;            // Latch writes, for checking
   logic [1:0] ctrl;                // Software control bits
   logic [3:0] lidx;                // Latch readback index
   logic [3:0] last_sel;            // Last accepted selector
   logic ignored;                   // Sticky: undefined selector
   sslp_cal_e cal_state;            // Calibration state
   logic [CAL_CNT_W-1:0] cal_cnt;   // Calibration cycle count
   logic apb_setup;                 // First cycle of a transfer
   logic apb_wr;                    // Write taking effect
   logic addr_hit;                  // Address is mapped
   logic [31:0] next_rdata;         // Read value before capture
   logic [7:0] addr;                // Low address byte

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   sslp_sync #(.WIDTH(3)) u_link_sync
   (
      .clock(clock),
      .nrst(nrst),
      .async_in({latch_strobe, serial_data, serial_clock}),
      .sync_out(link_s)
   );

   // Lock and scaled signals are asynchronous to this clock
   sslp_sync #(.WIDTH(4)) u_src_sync
   (
      .clock(clock),
      .nrst(nrst),
      .async_in({rf_scaled, ref_scaled, analog_lock, digital_lock}),
      .sync_out(src_s)
   );

   // ------------------------------------------------------------
   // Edge detection on the synchronised link
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         sclk_d <= 1'b0;
         strobe_d <= 1'b0;
      end
      else
      begin
         sclk_d <= link_s[0];
         strobe_d <= link_s[2];
      end
   end

   // Data and clock share one delay, so the data bit lines up
   assign sclk_rise = link_s[0] & ~sclk_d;
   assign strobe_rise = link_s[2] & ~strobe_d;
   assign wr_sel = shreg[SEL_LSB +: SEL_W];
   // Undefined selectors and a disabled link never write
   assign wr_evt = strobe_rise & ctrl[CTRL_LINK_BIT] &
      (wr_sel <= SEL_LAST);

   // ------------------------------------------------------------
   // Shift register, first bit ends up at the top
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         shreg <= LATCH_RST;
      else if (sclk_rise)
         shreg <= {shreg[WORD_W-2:0], link_s[1]};
   end

   // ------------------------------------------------------------
   // Latch bank, written by selector value
   // ------------------------------------------------------------
   // The strobe is trusted to come after the last bit
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < LATCH_COUNT; i++)
            latch_mem[i] <= LATCH_RST;
      end
      else if (wr_evt)
         latch_mem[wr_sel] <= shreg;
   end

   // Bookkeeping of writes and of strobes with an undefined selector
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         wr_count <= 8'h00;
         last_sel <= 4'h0;
         ignored <= 1'b0;
      end
      else
      begin
         if (wr_evt)
         begin
            wr_count <= wr_count + 8'h01;
            last_sel <= wr_sel;
         end
         // Setting wins over a clear in the same cycle
         if (strobe_rise && (wr_sel > SEL_LAST))
            ignored <= 1'b1;
         else if (apb_wr && addr == ADDR_STATUS && pwdata[8])
            ignored <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Settings in use, immediate and double buffered
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         active <= ACTIVE_RST;
         ref_differential <= 1'b0;
         mux_select <= MUX_LOW;
      end
      else if (wr_evt)
      begin
         if (wr_sel == REG_INT)
         begin
            // Commit point: other latches hold their newest words
            active.int_word <= shreg[INT_LSB +: INT_W];
            active.prescaler_89 <= shreg[PRESC_BIT];
            active.primary_fraction_numerator <=
               latch_mem[REG_PNUM][PNUM_LSB +: PNUM_W];
            active.aux_fraction_numerator <=
               latch_mem[REG_ANUM][ANUM_LSB +: AUX_W];
            active.aux_modulus <= latch_mem[REG_AMOD][AMOD_LSB +: AUX_W];
            active.doubler <= latch_mem[REG_REF][DBL_BIT];
            active.ref_halving_select <= latch_mem[REG_REF][HALV_BIT];
            active.ref_count <= latch_mem[REG_REF][RCNT_LSB +: RCNT_W];
            active.cp_current <= latch_mem[REG_REF][CP_LSB +: CP_W];
            if (latch_mem[REG_REF][DIVDB_BIT])
               active.out_div <=
                  latch_mem[REG_ODIV][ODIV_LSB +: ODIV_W];
         end
         else if (wr_sel == REG_REF)
         begin
            // Reference mode and mux select act at once
            ref_differential <= shreg[REF_DIFF_BIT];
            mux_select <= shreg[MUXSEL_LSB +: MUXSEL_W];
         end
         else if (wr_sel == REG_ODIV && !latch_mem[REG_REF][DIVDB_BIT])
            active.out_div <= shreg[ODIV_LSB +: ODIV_W];
      end
   end

   // ------------------------------------------------------------
   // Derived loop figures
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         integer_mode <= 1'b1;
         pfd_multiplier <= 2'h1;
         pfd_divisor <= 11'h000;
         config_valid <= 1'b0;
      end
      else
      begin
         integer_mode <= (active.primary_fraction_numerator == '0) &&
            (active.aux_fraction_numerator == '0);
         // Ratio is reference times multiplier over divisor
         pfd_multiplier <= {1'b0, active.doubler} + 2'h1;
         pfd_divisor <= active.ref_halving_select ?
            {active.ref_count, 1'b0} : {1'b0, active.ref_count};
         config_valid <= (active.ref_count >= RCNT_MIN) &&
            (active.aux_modulus >= AMOD_MIN) &&
            (active.int_word >= (active.prescaler_89 ?
            INT_MIN_89 : INT_MIN_45));
      end
   end

   // ------------------------------------------------------------
   // Output multiplexer, registered
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         test_mux_output <= 1'b0;
      else
      begin
         case (mux_select)
            MUX_HIGH: test_mux_output <= 1'b1;
            MUX_DLOCK: test_mux_output <= src_s[0];
            MUX_ALOCK: test_mux_output <= src_s[1];
            MUX_REF: test_mux_output <= src_s[2];
            MUX_RF: test_mux_output <= src_s[3];
            default: test_mux_output <= 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Band calibration after a commit
   // ------------------------------------------------------------
   // Fixed duration stands in for the analog band search
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         cal_state <= CAL_IDLE;
         cal_cnt <= '0;
      end
      else
      begin
         case (cal_state)
            CAL_IDLE:
            begin
               if (wr_evt && wr_sel == REG_INT && shreg[AUTOCAL_BIT] &&
                  ctrl[CTRL_CAL_BIT])
               begin
                  cal_state <= CAL_RUN;
                  cal_cnt <= CAL_CNT_W'(CAL_CYCLES - 1);
               end
            end
            CAL_RUN:
            begin
               // A new commit restarts the search
               if (wr_evt && wr_sel == REG_INT && shreg[AUTOCAL_BIT] &&
                  ctrl[CTRL_CAL_BIT])
                  cal_cnt <= CAL_CNT_W'(CAL_CYCLES - 1);
               else if (cal_cnt == '0)
                  cal_state <= CAL_IDLE;
               else
                  cal_cnt <= cal_cnt - 1'b1;
            end
            default: cal_state <= CAL_IDLE;
         endcase
      end
   end

   assign cal_busy = (cal_state == CAL_RUN);
   assign loop_active = ~cal_busy;

   // ------------------------------------------------------------
   // APB slave
   // ------------------------------------------------------------
   assign addr = paddr[7:0];
   assign apb_setup = psel & ~penable;
   assign pready = psel & penable;      // Zero wait states
   assign apb_wr = psel & penable & pwrite;
   // Whole address compared, so on wider buses only the clear of ignored aliases the map
   assign addr_hit = (paddr[1:0] == 2'h0) &&
      (paddr <= ADDR_W'(ADDR_INTCFG));
   assign pslverr = psel & penable & ~addr_hit;

   // Writable control and index registers
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         ctrl <= CTRL_RST;
         lidx <= 4'h0;
      end
      else if (apb_wr && addr_hit)
      begin
         if (addr == ADDR_CTRL)
            ctrl <= pwdata[1:0];
         else if (addr == ADDR_LIDX)
            lidx <= pwdata[3:0];
      end
   end

   // Read mux, captured in the setup cycle
   always_comb
   begin
      next_rdata = 32'h00000000;
      case (addr)
         ADDR_CTRL: next_rdata = {30'h0, ctrl};
         ADDR_STATUS: next_rdata = {20'h0, wr_count[2:0], ignored,
            last_sel, config_valid, integer_mode, ref_differential,
            cal_busy};
         ADDR_LIDX: next_rdata = {28'h0, lidx};
         ADDR_LDATA: next_rdata = (lidx <= SEL_LAST) ?
            latch_mem[lidx] : 32'h00000000;
         ADDR_PNUM: next_rdata = {8'h0, active.primary_fraction_numerator};
         ADDR_ANUM: next_rdata = {4'h0, active.aux_fraction_numerator};
         ADDR_AMOD: next_rdata = {4'h0, active.aux_modulus};
         ADDR_REFCFG: next_rdata = {13'h0, active.out_div,
            active.cp_current, active.doubler, active.ref_halving_select,
            active.ref_count};
         ADDR_INTCFG: next_rdata = {15'h0, active.prescaler_89,
            active.int_word};
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
         prdata <= 32'h00000000;
      else if (apb_setup)
         prdata <= (addr_hit && !pwrite) ? next_rdata : 32'h00000000;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   a_shift_in: assert property (@(posedge clock) disable iff (!nrst)
      sclk_rise |=> shreg == {$past(shreg[WORD_W-2:0]), $past(link_s[1])})
      else $error("shift register did not take the data bit");

   a_latch_copy: assert property (@(posedge clock) disable iff (!nrst)
      wr_evt |=> latch_mem[$past(wr_sel)] == $past(shreg))
      else $error("latch did not receive the shifted word");

   a_undef_ignored: assert property (@(posedge clock) disable iff (!nrst)
      (strobe_rise && wr_sel > SEL_LAST) |=> $stable(wr_count))
      else $error("undefined selector wrote a latch");

   a_dbuf_hold: assert property (@(posedge clock) disable iff (!nrst)
      (wr_evt && wr_sel == REG_PNUM) |=>
      $stable(active.primary_fraction_numerator))
      else $error("buffered numerator changed without commit");

   a_dbuf_commit: assert property (@(posedge clock) disable iff (!nrst)
      (wr_evt && wr_sel == REG_INT) |=> active.aux_modulus ==
      $past(latch_mem[REG_AMOD][AMOD_LSB +: AUX_W]))
      else $error("commit did not load the auxiliary modulus");

   a_div_direct: assert property (@(posedge clock) disable iff (!nrst)
      (wr_evt && wr_sel == REG_ODIV && !latch_mem[REG_REF][DIVDB_BIT])
      |=> active.out_div == $past(shreg[ODIV_LSB +: ODIV_W]))
      else $error("divider select did not act directly");

   a_ref_mode: assert property (@(posedge clock) disable iff (!nrst)
      (wr_evt && wr_sel == REG_REF) |=>
      ref_differential == $past(shreg[REF_DIFF_BIT]))
      else $error("reference mode not taken from its bit");

   a_int_mode: assert property (@(posedge clock) disable iff (!nrst)
      (active.primary_fraction_numerator == '0 &&
      active.aux_fraction_numerator == '0) |=> integer_mode)
      else $error("zero numerators did not give integer mode");

   a_mux_high: assert property (@(posedge clock) disable iff (!nrst)
      (mux_select == MUX_HIGH) [*2] |-> test_mux_output)
      else $error("mux output not high for the high code");

   a_cal_bound: assert property (@(posedge clock) disable iff (!nrst)
      $rose(cal_busy) |-> cal_busy [*8] ##[1:260] !cal_busy)
      else $error("calibration length out of range");

endmodule

// File: common/sslp_pkg.sv
// Shared constants, field layout and carrier types of the serial latch block
package sslp_pkg;

   // ------------------------------------------------------------
   // Word and selector layout
   // ------------------------------------------------------------
   localparam int WORD_W = 32;          // Serial word length
   localparam int SEL_LSB = 0;          // Selector field position
   localparam int SEL_W = 4;            // Selector field width
   localparam int LATCH_COUNT = 14;     // Latches 0 to 13
   localparam logic [3:0] SEL_LAST = 4'hD; // Highest defined selector

   // ------------------------------------------------------------
   // Latch numbers of interest
   // ------------------------------------------------------------
   localparam logic [3:0] REG_INT = 4'h0;   // Integer word, commit
   localparam logic [3:0] REG_PNUM = 4'h1;  // Primary numerator
   localparam logic [3:0] REG_ANUM = 4'h2;  // Auxiliary numerator
   localparam logic [3:0] REG_REF = 4'h4;   // Reference and mux
   localparam logic [3:0] REG_ODIV = 4'h6;  // Output divider
   localparam logic [3:0] REG_AMOD = 4'hD;  // Auxiliary modulus

   // ------------------------------------------------------------
   // Field positions inside latch words
   // ------------------------------------------------------------
   localparam int INT_LSB = 4;          // Integer word, latch 0
   localparam int INT_W = 16;
   localparam int PRESC_BIT = 20;       // 8/9 prescaler select
   localparam int AUTOCAL_BIT = 21;     // Auto calibration enable
   localparam int PNUM_LSB = 4;         // Primary numerator
   localparam int ANUM_LSB = 4;         // Auxiliary numerator
   localparam int AMOD_LSB = 4;         // Auxiliary modulus
   localparam int AUX_W = 28;
   localparam int REF_DIFF_BIT = 9;     // Differential reference
   localparam int CP_LSB = 10;          // Charge pump current
   localparam int CP_W = 4;
   localparam int DIVDB_BIT = 14;       // Divider double buffer
   localparam int RCNT_LSB = 15;        // Reference count
   localparam int RCNT_W = 10;
   localparam int HALV_BIT = 25;        // Reference halving
   localparam int DBL_BIT = 26;         // Reference doubler
   localparam int MUXSEL_LSB = 27;      // Mux select field
   localparam int MUXSEL_W = 3;
   localparam int ODIV_LSB = 21;        // Output divider select
   localparam int ODIV_W = 3;

   // ------------------------------------------------------------
   // Divider limits
   // ------------------------------------------------------------
   localparam logic [24:0] PRIMARY_MODULUS = 25'h1000000;
   localparam int PNUM_W = $clog2(PRIMARY_MODULUS);
   localparam logic [15:0] INT_MIN_45 = 16'h0017;   // 23
   localparam logic [15:0] INT_MIN_89 = 16'h004B;   // 75
   localparam logic [27:0] AMOD_MIN = 28'h0000002;
   localparam logic [9:0] RCNT_MIN = 10'h001;

   // ------------------------------------------------------------
   // Mux select codes
   // ------------------------------------------------------------
   localparam logic [2:0] MUX_LOW = 3'h0;
   localparam logic [2:0] MUX_HIGH = 3'h1;
   localparam logic [2:0] MUX_REF = 3'h2;
   localparam logic [2:0] MUX_RF = 3'h3;
   localparam logic [2:0] MUX_ALOCK = 3'h4;
   localparam logic [2:0] MUX_DLOCK = 3'h5;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 4;
   localparam int CAL_TIME_NS = 1000;   // Band selection time
   localparam int CAL_CYCLES = (CAL_TIME_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam int CAL_CNT_W = 9;

   // ------------------------------------------------------------
   // Register map of the bus slave
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LIDX = 8'h08;
   localparam logic [7:0] ADDR_LDATA = 8'h0C;
   localparam logic [7:0] ADDR_PNUM = 8'h10;
   localparam logic [7:0] ADDR_ANUM = 8'h14;
   localparam logic [7:0] ADDR_AMOD = 8'h18;
   localparam logic [7:0] ADDR_REFCFG = 8'h1C;
   localparam logic [7:0] ADDR_INTCFG = 8'h20;
   localparam int CTRL_LINK_BIT = 0;    // Accept latch strobes
   localparam int CTRL_CAL_BIT = 1;     // Allow calibration
   localparam logic [1:0] CTRL_RST = 2'h3;
   localparam logic [31:0] LATCH_RST = 32'h00000000;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] int_word;
      logic prescaler_89;
      logic [23:0] primary_fraction_numerator;
      logic [27:0] aux_fraction_numerator;
      logic [27:0] aux_modulus;
      logic doubler;
      logic ref_halving_select;
      logic [9:0] ref_count;
      logic [3:0] cp_current;
      logic [2:0] out_div;
   } sslp_active_s;

   localparam sslp_active_s ACTIVE_RST = '0;

   typedef enum logic [0:0] {CAL_IDLE, CAL_RUN} sslp_cal_e;

endpackage

// File: src/sslp_sync.sv
// Two flip-flop synchroniser for signals from outside the clock domain
`timescale 1ns/1ps
module sslp_sync
   import sslp_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic nrst,
   // Signals
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;  // Read only by the second stage

   // ------------------------------------------------------------
   // Synchroniser chain
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end

endmodule

// File: sim/sslp_host.sv
// Host model driving words over the three wire link
`timescale 1ns/1ps
module sslp_host
(
   // Clock
   input wire logic clock,
   // Link pins
   output logic serial_clock,
   output logic serial_data,
   output logic latch_strobe
);
   // Link clock idles low between frames
   initial {serial_clock, serial_data, latch_strobe} = 3'h0;
   // One word, 8 clocks per bit, data moves while link clock is low
   task automatic send(input logic [31:0] w);
      for (int i = 31; i >= 0; i--)
      begin
         serial_data <= w[i];
         repeat (4) @(posedge clock);
         serial_clock <= 1'b1;
         repeat (4) @(posedge clock);
         serial_clock <= 1'b0;
      end
      repeat (4) @(posedge clock);
      latch_strobe <= 1'b1;
      serial_data <= ~w[0]; // Released line shows no stale bit
      repeat (4) @(posedge clock);
      latch_strobe <= 1'b0;
      repeat (12) @(posedge clock);
   endtask
endmodule

// File: sim/sslp_top_tb.sv
// Self-checking bench of the serial latch block
`timescale 1ns/1ps
module sslp_top_tb;
   import sslp_pkg::*;
   logic clock = 1'b0, nrst = 1'b0, sclk, sdat, lstr;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ev;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rv;
   logic pready, pslverr, rdiff, imode, cvalid, mout, cbusy, lact;
   logic [2:0] msel;
   logic [1:0] pmul;
   logic [10:0] pdiv;
   logic [3:0] src = 4'h9;
   logic [11:0] pats = 12'h639;
   logic [17:0] exps = {6'h16, 6'h32, 6'h2A};
   sslp_active_s act;
   int fails = 0, cmp_count = 0;
   always #2 clock = ~clock;
   sslp_host host (.clock(clock), .serial_clock(sclk),
      .serial_data(sdat), .latch_strobe(lstr));
   sslp_top dut (.clock(clock), .nrst(nrst), .serial_clock(sclk),
      .serial_data(sdat), .latch_strobe(lstr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .digital_lock(src[0]), .analog_lock(src[1]),
      .ref_scaled(src[2]), .rf_scaled(src[3]), .active(act),
      .ref_differential(rdiff), .mux_select(msel),
      .integer_mode(imode), .pfd_multiplier(pmul), .pfd_divisor(pdiv),
      .config_valid(cvalid), .test_mux_output(mout),
      .cal_busy(cbusy), .loop_active(lact));
   // Compare and count
   task automatic chk(input logic [127:0] s, input logic [127:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("BAD %0t seen %0h expected %0h", $time, s, e);
      end
   endtask
   // One APB transfer, waits for pready under a bound
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clock);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1 && ++n < 16);
      rv = prdata;
      ev = pslverr;
      {psel, penable} <= 2'h0;
      if (n >= 16)
      begin
         fails++;
         summarize;
      end
   endtask
   task automatic summarize;
      $display("Comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      #400000;
      fails++;
      summarize;
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clock);
      nrst <= 1'b1;
      apb(0, ADDR_CTRL, 0);
      chk(rv, 32'(CTRL_RST));
      apb(0, 8'h40, 0);
      chk(ev, 1'b1);
      host.send({4'h0, 24'hABCDE5, REG_PNUM});
      chk(act.primary_fraction_numerator, 24'h0);
      apb(1, ADDR_LIDX, 32'h1);
      apb(0, ADDR_LDATA, 0);
      chk(rv, 32'h0ABCDE51);
      for (int m = 0; m < 6; m++)
      begin
         // Bit 7 carries positive detector polarity
         host.send({2'h0, m[2:0], 2'h3, 10'h005, 6'h1, 5'h8,
            REG_REF});
         chk(msel, m[2:0]);
         // Three source patterns tell every mux code apart
         for (int p = 0; p < 3; p++)
         begin
            src <= pats[p*4 +: 4];
            repeat (4) @(posedge clock);
            chk(mout, exps[p*6 + m]);
         end
      end
      chk(rdiff, 1'b1);
      chk(pdiv, 11'h000);
      host.send({8'h0, 3'h5, 17'h0, REG_ODIV});
      chk(act.out_div, 3'h5);
      host.send({2'h0, 3'h5, 2'h3, 10'h005, 6'h21, 5'h8,
         REG_REF});
      host.send({8'h0, 3'h2, 17'h0, REG_ODIV});
      chk(act.out_div, 3'h5);
      host.send({10'h0, 2'h2, 16'h0064, REG_INT});
      chk(cbusy, 1'b1);
      chk(lact, 1'b0);
      chk(act.primary_fraction_numerator, 24'hABCDE5);
      chk(act.out_div, 3'h2);
      chk(pdiv, 11'h00A);
      chk(pmul, 2'h2);
      chk(imode, 1'b0);
      chk(cvalid, 1'b0);
      repeat (250) @(posedge clock);
      chk(lact, 1'b1);
      host.send({28'hFFFFFFF, 4'hE});
      apb(0, ADDR_STATUS, 0);
      chk(rv[8], 1'b1);
      chk(act.int_word, 16'h0064);
      apb(1, ADDR_STATUS, 32'h100);
      apb(0, ADDR_STATUS, 0);
      chk(rv[8], 1'b0);
      // Strobes refused while the link is switched off
      apb(1, ADDR_CTRL, 32'h2);
      host.send({4'h0, 24'h123456, REG_PNUM});
      apb(0, ADDR_LDATA, 0);
      chk(rv, 32'h0ABCDE51);
      apb(1, ADDR_CTRL, 32'(CTRL_RST));
      host.send({4'h0, 24'h0, REG_PNUM});
      host.send({28'h2, REG_AMOD});
      host.send({12'h0, 16'h0017, REG_INT});
      chk(imode, 1'b1);
      chk(cvalid, 1'b1);
      chk(act.aux_modulus, 28'h2);
      host.send({11'h0, 1'h1, 16'h0017, REG_INT});
      chk(cvalid, 1'b0);
      summarize;
   end
endmodule
